// ### pkg/dac_loader_pkg.sv
// Overview of operation
// - 24-bit shift register, word sent MSB first
// - data sampled on rising serial clock edge
// - word is 8-bit address, 16-bit data
// - latch rising edge captures last 24 bits
// - shifting continues regardless of latch level
// - host gives exactly 24 edges before latch
// - short or long bit count makes word invalid
// - host latches right after correct count
// - first MSB edge starts a write cycle
// - serial clock no faster than 30 MHz
// - top four code bits become 15-line thermometer
// - code bits 11:4 or 11:0 drive ladder switches
// - configuration selects one of three ranges
// - address 0x01 loads the code register
// - address 0x55 loads the configuration register
// - latch loads addressed register, code updates output
// - clear forces zero-scale output of range
package dac_loader_pkg;
	localparam int          WORD_BITS      = 24;
	localparam int          DATA_BITS      = 16;
	localparam int          ADDR_BITS      = 8;
	localparam int          CNT_BITS       = 5;
	localparam int          THERMO_LINES   = 15;
	localparam int          LADDER_BITS    = 12;
	localparam logic [7:0]  ADDR_NOP       = 8'h00;
	localparam logic [7:0]  ADDR_CODE      = 8'h01;
	localparam logic [7:0]  ADDR_CONFIG    = 8'h55;
	localparam logic [15:0] CODE_RESET     = 16'h0000;
	localparam logic [15:0] CONFIG_RESET   = 16'h0000;
	localparam int          RANGE_LSB      = 0;
	localparam int          OUTEN_BIT      = 12;
	localparam logic [2:0]  RANGE_4_20     = 3'h5;
	localparam logic [2:0]  RANGE_0_20     = 3'h6;
	localparam logic [2:0]  RANGE_0_24     = 3'h7;
	localparam int          CLK_MHZ        = 40;
	localparam int          SCLK_MAX_MHZ   = 30;
	localparam int          SCLK_DIV       = (CLK_MHZ + SCLK_MAX_MHZ - 1)
		/ SCLK_MAX_MHZ;
	localparam int          HALF_CYCLES    = SCLK_DIV;
endpackage

// ### pkg/dac_link_if.sv
`timescale 1ns/10ps
interface dac_link_if;
	logic serial_clock;
	logic serial_in_line;
	logic latch;
	modport host (output serial_clock, output serial_in_line, output latch);
	modport device (input serial_clock, input serial_in_line, input latch);
endinterface

// ### rtl/dac_host_end.sv
`timescale 1ns/10ps
module dac_host_end
	import dac_loader_pkg::*;
(
	input  wire logic                 clock_in,
	input  wire logic                 sys_rst_in,
	input  wire logic                 send_in,
	input  wire logic [WORD_BITS-1:0] word_in,
	output logic                      busy_out,
	output logic                      done_out,
	dac_link_if.host                  link
);
	typedef enum logic [1:0] {IDLE, LOW, HIGH, LATCHING} phase_t;
	typedef struct packed {
		phase_t                phase;
		logic [WORD_BITS-1:0]  shift;
		logic [CNT_BITS-1:0]   bits;
		logic [1:0]            wait_cnt;
		logic                  sclk;
		logic                  sdo;
		logic                  latch;
		logic                  busy;
		logic                  done;
	} host_state_t;
	host_state_t state_reg, state_next;

	always_comb begin
		state_next = state_reg;
		state_next.done = 1'b0;
		unique case (state_reg.phase)
			IDLE: begin
				state_next.latch = 1'b0;
				if (send_in) begin
					state_next.shift = word_in;
					state_next.bits = CNT_BITS'(WORD_BITS);
					state_next.phase = LOW;
					state_next.wait_cnt = 2'h0;
					state_next.busy = 1'b1;
				end
			end
			LOW: begin
				// data set up while clock is low, stable at rising edge
				state_next.sclk = 1'b0;
				state_next.sdo = state_reg.shift[WORD_BITS-1];
				if (state_reg.wait_cnt == 2'(HALF_CYCLES - 1)) begin
					state_next.wait_cnt = 2'h0;
					state_next.phase = HIGH;
				end else begin
					state_next.wait_cnt = state_reg.wait_cnt + 2'h1;
				end
			end
			HIGH: begin
				state_next.sclk = 1'b1;
				if (state_reg.wait_cnt == 2'(HALF_CYCLES - 1)) begin
					state_next.wait_cnt = 2'h0;
					state_next.shift = {state_reg.shift[WORD_BITS-2:0], 1'b0};
					state_next.bits = state_reg.bits - 5'h01;
					// gated burst of exactly 24 edges
					if (state_reg.bits == 5'h01) begin
						state_next.phase = LATCHING;
					end else begin
						state_next.phase = LOW;
					end
				end else begin
					state_next.wait_cnt = state_reg.wait_cnt + 2'h1;
				end
			end
			LATCHING: begin
				state_next.sclk = 1'b0;
				state_next.latch = 1'b1;
				state_next.phase = IDLE;
				state_next.busy = 1'b0;
				state_next.done = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign link.serial_clock = state_reg.sclk;
	assign link.serial_in_line = state_reg.sdo;
	assign link.latch = state_reg.latch;
	assign busy_out = state_reg.busy;
	assign done_out = state_reg.done;
endmodule

// ### rtl/dac_device_end.sv
`timescale 1ns/10ps
module dac_device_end
	import dac_loader_pkg::*;
(
	input  wire logic                    clock_in,
	input  wire logic                    sys_rst_in,
	input  wire logic                    clear_in,
	input  wire logic                    wide_mode_in,
	output logic [THERMO_LINES-1:0]      thermometer_segment_controls_out,
	output logic [LADDER_BITS-1:0]       ladder_switch_controls_out,
	output logic [2:0]                   range_out,
	output logic                         output_enable_out,
	output logic                         zero_scale_out,
	output logic                         word_error_out,
	dac_link_if.device                   link
);
	typedef struct packed {
		logic [2:0]            sclk_sync;
		logic [2:0]            sdi_sync;
		logic [2:0]            latch_sync;
		logic [1:0]            clr_sync;
		logic [WORD_BITS-1:0]  shift;
		logic [CNT_BITS:0]     edges;
		logic [DATA_BITS-1:0]  code;
		logic [DATA_BITS-1:0]  config_word;
		logic [THERMO_LINES-1:0] thermo;
		logic [LADDER_BITS-1:0] ladder;
		logic                  zero;
		logic                  error;
	} dev_state_t;
	dev_state_t state_reg, state_next;

	logic                    sclk_rise;
	logic                    latch_rise;
	logic [ADDR_BITS-1:0]    addr_field;
	logic [DATA_BITS-1:0]    data_field;
	logic                    code_load;
	logic [DATA_BITS-1:0]    code_eff;
	logic [3:0]              seg;
	logic [THERMO_LINES-1:0] thermo_v;
	logic [LADDER_BITS-1:0]  ladder_v;

	// only stage 1 and 2 feed edge detection; stage 0 stays private
	assign sclk_rise  = state_reg.sclk_sync[1] & ~state_reg.sclk_sync[2];
	assign latch_rise = state_reg.latch_sync[1] & ~state_reg.latch_sync[2];
	assign addr_field = state_reg.shift[WORD_BITS-1 -: ADDR_BITS];
	assign data_field = state_reg.shift[DATA_BITS-1:0];
	assign code_load  = latch_rise && addr_field == ADDR_CODE
		&& state_reg.edges == 6'(WORD_BITS);
	// decoded outside the state process so the segment lines form no loop;
	// clear wins over a load in the same cycle
	assign code_eff   = state_reg.clr_sync[1] ? {DATA_BITS{1'b0}}
		: (code_load ? data_field : state_reg.code);
	assign seg        = code_eff[DATA_BITS-1 -: 4];

	generate
		for (genvar i = 0; i < THERMO_LINES; i++) begin : g_thermo
			assign thermo_v[i] = (seg > 4'(i));
		end
	endgenerate

	always_comb begin
		state_next = state_reg;
		state_next.sclk_sync  = {state_reg.sclk_sync[1:0], link.serial_clock};
		state_next.sdi_sync   = {state_reg.sdi_sync[1:0], link.serial_in_line};
		state_next.latch_sync = {state_reg.latch_sync[1:0], link.latch};
		state_next.clr_sync   = {state_reg.clr_sync[0], clear_in};
		// sampling is keyed to the synchronised edge, so the link must run
		// well below the system clock; 30 MHz host needs a faster clock_in
		if (sclk_rise) begin
			state_next.shift = {state_reg.shift[WORD_BITS-2:0],
				state_reg.sdi_sync[2]};
			// count saturates so over-long frames stay detectable
			if (state_reg.edges != '1) begin
				state_next.edges = state_reg.edges + 6'h01;
			end
		end
		if (latch_rise) begin
			state_next.edges = '0;
			if (state_reg.edges != 6'(WORD_BITS)) begin
				state_next.error = 1'b1;
			end else begin
				state_next.error = 1'b0;
				unique case (addr_field)
					ADDR_CODE:   state_next.code = data_field;
					ADDR_CONFIG: state_next.config_word = data_field;
					default:     ;
				endcase
			end
		end
		if (wide_mode_in) begin
			ladder_v = code_eff[LADDER_BITS-1:0];
		end else begin
			ladder_v = {4'h0, code_eff[DATA_BITS-5 -: 8]};
		end
		state_next.thermo = thermo_v;
		state_next.ladder = ladder_v;
		state_next.zero = state_reg.clr_sync[1];
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign thermometer_segment_controls_out = state_reg.thermo;
	assign ladder_switch_controls_out = state_reg.ladder;
	assign range_out = state_reg.config_word[RANGE_LSB +: 3];
	assign output_enable_out = state_reg.config_word[OUTEN_BIT];
	assign zero_scale_out = state_reg.zero;
	assign word_error_out = state_reg.error;
endmodule

// ### tb/dac_link_props.sv
`timescale 1ns/10ps
module dac_link_props (
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic serial_clock,
	input wire logic serial_in_line,
	input wire logic latch
);
	logic [5:0] cnt_reg;
	logic       latch_q;
	logic       sclk_q;
	// rises of the serial clock since the last commit; own edge
	// detection keeps the counter clear of clock inference
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt_reg <= 6'h00;
			latch_q <= 1'b0;
			sclk_q  <= 1'b0;
		end else begin
			latch_q <= latch;
			sclk_q  <= serial_clock;
			if (latch && !latch_q)
				cnt_reg <= 6'h00;
			else if (serial_clock && !sclk_q && cnt_reg != 6'h3F)
				cnt_reg <= cnt_reg + 6'h01;
		end
	end
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	chk_count_at_commit: assert property (
		$rose(latch) |-> cnt_reg == 6'h18) else $error("bad edge count");
	chk_data_held: assert property (
		serial_clock |-> $stable(serial_in_line)) else $error("data moved");
	chk_high_time: assert property (
		$rose(serial_clock) |=> serial_clock ##1 !serial_clock)
		else $error("clock high time");
	chk_low_time: assert property (
		$fell(serial_clock) |=> !serial_clock) else $error("clock low time");
	chk_bit_pace: assert property (
		$rose(serial_clock) && cnt_reg < 6'h17 |-> ##4 $rose(serial_clock))
		else $error("bit pace");
	chk_commit_after: assert property (
		$rose(serial_clock) && cnt_reg == 6'h17 |-> ##[1:6] $rose(latch))
		else $error("late commit");
	chk_idle_low: assert property (
		latch |-> !serial_clock) else $error("clock during latch");
	chk_frame_start: assert property (
		$rose(serial_clock) && cnt_reg == 6'h00
		|-> !$past(serial_clock, 2)
		&& $past(serial_in_line, 2) == serial_in_line)
		else $error("no start");
endmodule

// ### tb/dac_serial_word_loader_tb_top.sv
`timescale 1ns/10ps
module dac_serial_word_loader_tb_top;
	import dac_loader_pkg::*;
	logic clock_in = 0, sys_rst_in = 1, send_in = 0, clr = 0, wide = 0;
	logic [23:0] word_in = 0, sh;
	logic busy_out, done_out, err, err_b, oe, zs;
	logic [14:0] th, th_b;
	logic [11:0] ld;
	logic [2:0] rg;
	logic [15:0] code = 0, cfg = 0;
	logic [32:0] eq[$];
	logic [23:0] wq[$];
	logic [7:0] adr[4] = '{8'h01, 8'h55, 8'h00, 8'h02};
	int errors = 0, n_tests = 0, nb = 0, k;
	dac_link_if link();
	dac_link_if link_b();
	dac_host_end i_dac_host_end(.clock_in, .sys_rst_in, .send_in, .word_in,
		.busy_out, .done_out, .link(link.host));
	dac_device_end i_dac_device_end(.clock_in, .sys_rst_in, .clear_in(clr),
		.wide_mode_in(wide), .thermometer_segment_controls_out(th),
		.ladder_switch_controls_out(ld), .range_out(rg),
		.output_enable_out(oe), .zero_scale_out(zs), .word_error_out(err),
		.link(link.device));
	// second device fed by a hand-driven link that sends 23, 24 and 25 edges per frame
	dac_device_end i_dac_device_end_b(.clock_in, .sys_rst_in,
		.clear_in(1'b0), .wide_mode_in(1'b0),
		.thermometer_segment_controls_out(th_b),
		.ladder_switch_controls_out(), .range_out(),
		.output_enable_out(), .zero_scale_out(), .word_error_out(err_b),
		.link(link_b.device));
	dac_link_props i_dac_link_props(.clock_in, .sys_rst_in,
		.serial_clock(link.serial_clock),
		.serial_in_line(link.serial_in_line), .latch(link.latch));
	initial forever #12.5 clock_in = ~clock_in;
	function automatic logic [32:0] expv();
		logic [15:0] t;
		t = (16'h0001 << code[15:12]) - 16'h0001;
		return {clr ? 15'h0000 : t[14:0], clr ? 12'h000 :
			(wide ? code[11:0] : {4'h0, code[11:4]}), cfg[2:0], cfg[12], clr,
			1'b0};
	endfunction
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		n_tests++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic send(input logic [23:0] w);
		int i;
		send_in = 1;
		word_in = w;
		if (w[23:16] == 8'h01) code = w[15:0];
		if (w[23:16] == 8'h55) cfg = w[15:0];
		wq.push_back(w);
		eq.push_back(expv());
		@(posedge clock_in) #1;
		send_in = 0;
		chk({32'h0, busy_out}, 33'h1);
		for (i = 0; i < 300 && done_out !== 1'b1; i++) @(posedge clock_in) #1;
		if (i == 300) begin
			errors++;
			close_out;
		end
		chk({32'h0, busy_out}, 33'h0);
		// outputs settle some cycles after the commit
		repeat (8) @(posedge clock_in) #1;
	endtask
	task automatic bang(input logic [23:0] w, input int n);
		for (int i = 0; i < n; i++) begin
			link_b.serial_in_line = w[(47 - i) % 24];
			repeat (4) @(posedge clock_in) #1;
			link_b.serial_clock = 1;
			repeat (4) @(posedge clock_in) #1;
			link_b.serial_clock = 0;
		end
		// released data line shows the inverse of the last bit
		link_b.serial_in_line = ~link_b.serial_in_line;
		link_b.latch = 1;
		repeat (8) @(posedge clock_in) #1;
		link_b.latch = 0;
	endtask
	always @(posedge link.serial_clock) begin
		sh = {sh[22:0], link.serial_in_line};
		nb++;
	end
	always @(posedge link.latch) begin
		chk({9'h000, sh}, {9'h000, wq.pop_front()});
		chk(33'(nb), 33'h18);
		nb = 0;
	end
	always @(posedge clock_in) begin
		#1;
		if (done_out === 1'b1) begin
			repeat (6) @(posedge clock_in) #1;
			chk({th, ld, rg, oe, zs, err}, eq.pop_front());
		end
	end
	initial begin
		link_b.serial_clock = 0;
		link_b.serial_in_line = 0;
		link_b.latch = 0;
		void'($urandom(21149));
		repeat (20) @(posedge clock_in) #1;
		sys_rst_in = 0;
		chk({th, ld, rg, oe, zs, err}, 33'h0);
		send({8'h01, 16'hFFFF});
		for (k = 0; k < 12; k++) begin
			wide = 1'($urandom);
			send({adr[k % 4], 13'($urandom), 3'h5 + 3'(k / 4)});
		end
		clr = 1;
		repeat (6) @(posedge clock_in) #1;
		chk({th, ld, rg, oe, zs, err}, expv());
		clr = 0;
		repeat (6) @(posedge clock_in) #1;
		chk({th, ld, rg, oe, zs, err}, expv());
		// miscounted frames leave address 0x01 in place, so a load shows
		bang(24'h03FFFE, 23);
		chk({17'h0, err_b, th_b}, {17'h0, 1'b1, 15'h0000});
		bang(24'h01F00F, 24);
		chk({17'h0, err_b, th_b}, {17'h0, 1'b0, 15'h7FFF});
		bang(24'h00C000, 25);
		chk({17'h0, err_b, th_b}, {17'h0, 1'b1, 15'h7FFF});
		close_out;
	end
endmodule
